//--- verilog/spi_port_and_status_pins.v
/*
  Host-facing pin logic: serial register port, interrupt or
  reference-missing pin, rate-select pin with general I/O use.
  Assumes the serial master drives chip select and serial clock, the
  activity monitor runs on mclk_i, and rst_i is synchronous.
*/
//
// Function
// - Rate pin latched into defaults at release.
// - Latched 0 picks SDH, 1 picks SONET.
// - Rate pin becomes general I/O after release.
// - Mode bit picks interrupt or reference-missing.
// - Interrupt mode: polarity, drive, general output.
// - Missing mode follows monitor live, unlatched.
// - Master data arrives on serial input pin.
// - Device returns read data on output pin.
// - Phase input picks leading or trailing sampling.
// - SONET allows 1.544MHz, SDH allows 2.048MHz.
// - Reset holds all state except the pin synchronisers at default values.
`include "spi_port_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module spi_port_and_status_pins (
	// Clock and reset.
	input wire mclk_i,
	input wire rst_i,
	// Parallel register port.
	input wire [6:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	output reg [7:0] reg_rdata_o,
	// Serial port pins.
	input wire spi_cs_n_i,
	input wire spi_sclk_i,
	input wire spi_sdi_i,
	input wire serial_clock_phase_select_i,
	output wire spi_sdo_o,
	output wire spi_sdo_oe_n_o,
	// Rate-select / general I/O pin.
	input wire general_io_pin4_i,
	output reg general_io_pin4_o,
	output reg general_io_pin4_oe_n_o,
	// Interrupt request / reference-missing pin.
	output reg interrupt_request_pin_o,
	output reg interrupt_request_pin_oe_n_o,
	// Activity monitor of the selected reference.
	input wire ref_missing_i,
	// Mode outputs toward the clock path.
	output wire sonet_rate_select_o,
	output wire digital_out1_standard_sel_o,
	output wire digital_out2_standard_sel_o,
	output wire freq_1544_avail_o,
	output wire freq_2048_avail_o,
	// Internal interrupt level.
	output wire irq_o
);

	// ==========================================================
	// Serial slave.
	wire [6:0] ser_addr; // Serial access address.
	wire [7:0] ser_wdata; // Serial write data.
	wire ser_wr; // Serial write strobe.
	wire ser_rd; // Serial read strobe.
	wire ser_done; // Serial frame completed.
	reg [7:0] ser_rdata_q; // Read answer toward the serial slave.

	// Clock and chip select are only received, never driven.
	serial_slave #(
		.ADDR_W(`SER_ADDR_BITS),
		.DATA_W(`SER_DATA_BITS)
	) u_serial (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.cs_n_i(spi_cs_n_i),
		.sclk_i(spi_sclk_i),
		.sdi_i(spi_sdi_i),
		.phase_i(serial_clock_phase_select_i),
		.sdo_o(spi_sdo_o),
		.sdo_oe_n_o(spi_sdo_oe_n_o),
		.addr_o(ser_addr),
		.wdata_o(ser_wdata),
		.wr_o(ser_wr),
		.rd_o(ser_rd),
		.rdata_i(ser_rdata_q),
		.frame_done_o(ser_done)
	);

	// ==========================================================
	// Pin synchronisers.
	reg pin4_m_q, pin4_s_q, pin4_p_q; // Rate/general pin and past value.
	reg rst_p_q; // Reset seen in the previous cycle.

	// The synchroniser keeps running through reset so that the pin
	// level is already settled on the first cycle after release.
	always @(posedge mclk_i) begin
		pin4_m_q <= general_io_pin4_i;
		pin4_s_q <= pin4_m_q;
		pin4_p_q <= pin4_s_q;
		rst_p_q <= rst_i;
	end

	wire release_w = rst_p_q & ~rst_i; // First cycle after reset.

	// ==========================================================
	// Write selection.
	// The parallel port wins a same-cycle collision; the serial write
	// of that cycle is lost, which only matters if both masters run.
	wire wr_en = reg_wr_i | ser_wr;
	wire [6:0] wr_addr = reg_wr_i ? reg_addr_i : ser_addr;
	wire [7:0] wr_data = reg_wr_i ? reg_wdata_i : ser_wdata;

	// ==========================================================
	// Configuration registers.
	reg sonet_q; // SONET (1) or SDH (0) rate family.
	reg dig1_sel_q; // Digital output 1 standard select.
	reg dig2_sel_q; // Digital output 2 standard select.
	reg [7:0] io_cfg_q; // Direction and output value of pin 4.
	reg [7:0] irq_cfg_q; // Interrupt pin configuration.

	// All state is at default while reset is high.
	always @(posedge mclk_i) begin
		if (rst_i) begin
			sonet_q <= 1'b0;
			dig1_sel_q <= 1'b0;
			dig2_sel_q <= 1'b0;
			io_cfg_q <= `RST_IO_PIN_CONFIG;
			irq_cfg_q <= `RST_IRQ_PIN_CONFIG;
		end else if (release_w) begin
			// Pin level becomes the mode defaults at release.
			sonet_q <= pin4_s_q;
			dig1_sel_q <= pin4_s_q;
			dig2_sel_q <= pin4_s_q;
		end else if (wr_en) begin
			case (wr_addr)
				`OFS_MASTER_CFG_THREE: begin
					sonet_q <= wr_data[`BIT_SONET_RATE];
				end
				`OFS_MASTER_CFG_SIX: begin
					dig1_sel_q <= wr_data[`BIT_DIG1_SEL];
					dig2_sel_q <= wr_data[`BIT_DIG2_SEL];
				end
				`OFS_IO_PIN_CONFIG: begin
					io_cfg_q <= wr_data;
				end
				`OFS_IRQ_PIN_CONFIG: begin
					irq_cfg_q <= wr_data;
				end
				default: begin
					// Other offsets hold no configuration.
				end
			endcase
		end
	end

	// Latched 0 means SDH on 2.048MHz, 1 means SONET on 1.544MHz.
	assign sonet_rate_select_o = sonet_q;
	assign digital_out1_standard_sel_o = dig1_sel_q;
	assign digital_out2_standard_sel_o = dig2_sel_q;
	assign freq_1544_avail_o = sonet_q;
	assign freq_2048_avail_o = ~sonet_q;

	// ==========================================================
	// Interrupt status and mask.
	reg [`NUM_EVENTS-1:0] status_q; // Sticky event bits.
	reg [`NUM_EVENTS-1:0] mask_q; // Enable per event.
	reg ref_prev_q; // Monitor level one cycle ago.
	wire [`NUM_EVENTS-1:0] event_w; // One-cycle event pulses.
	wire [`NUM_EVENTS-1:0] clear_w; // Write-one-to-clear pulses.

	assign event_w[`BIT_EV_REF_LOST] = ref_missing_i & ~ref_prev_q;
	assign event_w[`BIT_EV_PIN4_CHANGE] =
		(pin4_s_q ^ pin4_p_q) & ~io_cfg_q[`BIT_PIN4_DIR] & ~rst_p_q;
	assign event_w[`BIT_EV_SER_FRAME] = ser_done;
	assign clear_w = (wr_en && wr_addr == `OFS_INT_STATUS) ?
		wr_data[`NUM_EVENTS-1:0] : {`NUM_EVENTS{1'b0}};

	// A new event wins over a clear in the same cycle.
	wire [`NUM_EVENTS-1:0] status_d; // Next sticky value per event.
	genvar gi;
	generate
		for (gi = 0; gi < `NUM_EVENTS; gi = gi + 1) begin : g_status
			assign status_d[gi] = event_w[gi] |
				(status_q[gi] & ~clear_w[gi]);
		end
	endgenerate

	// One process owns the whole status word, so it has one driver.
	always @(posedge mclk_i) begin
		if (rst_i) begin
			status_q <= {`NUM_EVENTS{1'b0}};
		end else begin
			status_q <= status_d;
		end
	end

	// Mask register and monitor history.
	always @(posedge mclk_i) begin
		if (rst_i) begin
			mask_q <= `RST_INT_MASK;
			ref_prev_q <= 1'b0;
		end else begin
			ref_prev_q <= ref_missing_i;
			if (wr_en && wr_addr == `OFS_INT_MASK) begin
				mask_q <= wr_data[`NUM_EVENTS-1:0];
			end
		end
	end

	assign irq_o = |(status_q & mask_q);

	// ==========================================================
	// Interrupt request / reference-missing pin.
	reg irq_level; // Level the pin should show.
	reg irq_oe_n; // Pin released when high.

	// Mode bit chooses the function; open drain only pulls low.
	always @* begin
		irq_level = 1'b0;
		irq_oe_n = 1'b0;
		if (irq_cfg_q[`BIT_REF_MISSING_MODE]) begin
			// Live monitor state, nothing latched.
			irq_level = ref_missing_i;
		end else begin
			if (irq_cfg_q[`BIT_IRQ_GP_MODE]) begin
				irq_level = irq_cfg_q[`BIT_IRQ_GP_VALUE];
			end else if (irq_cfg_q[`BIT_IRQ_ACT_HIGH]) begin
				irq_level = irq_o;
			end else begin
				irq_level = ~irq_o;
			end
			if (irq_cfg_q[`BIT_IRQ_OPEN_DRAIN]) begin
				irq_oe_n = irq_level;
			end
		end
	end

	// Pin 4 drives only as an output after release.
	always @(posedge mclk_i) begin
		if (rst_i) begin
			interrupt_request_pin_o <= 1'b0;
			interrupt_request_pin_oe_n_o <= 1'b1;
			general_io_pin4_o <= 1'b0;
			general_io_pin4_oe_n_o <= 1'b1;
		end else begin
			interrupt_request_pin_o <= irq_level;
			interrupt_request_pin_oe_n_o <= irq_oe_n;
			general_io_pin4_o <= io_cfg_q[`BIT_PIN4_OUT];
			general_io_pin4_oe_n_o <= ~io_cfg_q[`BIT_PIN4_DIR];
		end
	end

	// ==========================================================
	// Read path.
	reg [7:0] rd_mux; // Value at the addressed register.
	reg [6:0] rd_addr; // Address of the current read.

	// Unmapped offsets read as zero; reads have no side effects.
	always @* begin
		rd_addr = reg_rd_i ? reg_addr_i : ser_addr;
		rd_mux = 8'h00;
		case (rd_addr)
			`OFS_MASTER_CFG_THREE: begin
				rd_mux[`BIT_SONET_RATE] = sonet_q;
			end
			`OFS_MASTER_CFG_SIX: begin
				rd_mux[`BIT_DIG1_SEL] = dig1_sel_q;
				rd_mux[`BIT_DIG2_SEL] = dig2_sel_q;
			end
			`OFS_IO_PIN_CONFIG: begin
				rd_mux = io_cfg_q;
			end
			`OFS_IO_PIN_STATE: begin
				rd_mux[`BIT_PIN4_STATE] = pin4_s_q;
			end
			`OFS_IRQ_PIN_CONFIG: begin
				rd_mux = irq_cfg_q;
			end
			`OFS_INT_STATUS: begin
				rd_mux[`NUM_EVENTS-1:0] = status_q;
			end
			`OFS_INT_MASK: begin
				rd_mux[`NUM_EVENTS-1:0] = mask_q;
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	// The parallel port gets its answer one cycle after its strobe; the serial port too, unless a parallel read shares the cycle.
	always @(posedge mclk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
			ser_rdata_q <= 8'h00;
		end else begin
			if (reg_rd_i) begin
				reg_rdata_o <= rd_mux;
			end
			if (ser_rd && !reg_rd_i) begin
				ser_rdata_q <= rd_mux;
			end
		end
	end

endmodule // spi_port_and_status_pins

`default_nettype wire

//--- verilog/spi_port_regs.vh
/*
  Register offsets, field positions, reset values and serial frame
  counts for the serial port and status pin block.
  Assumes it is included by bare name from files under verilog/.
*/
`ifndef SPI_PORT_REGS_VH
`define SPI_PORT_REGS_VH

// ==========================================================
// Register indices on the 7-bit register address.
`define OFS_MASTER_CFG_THREE 7'h00
`define OFS_MASTER_CFG_SIX 7'h01
`define OFS_IO_PIN_CONFIG 7'h02
`define OFS_IO_PIN_STATE 7'h03
`define OFS_IRQ_PIN_CONFIG 7'h04
`define OFS_INT_STATUS 7'h05
`define OFS_INT_MASK 7'h06

// ==========================================================
// Field positions.
`define BIT_SONET_RATE 0
`define BIT_DIG1_SEL 0
`define BIT_DIG2_SEL 1
`define BIT_PIN4_DIR 0
`define BIT_PIN4_OUT 1
`define BIT_PIN4_STATE 0
`define BIT_REF_MISSING_MODE 0
`define BIT_IRQ_ACT_HIGH 1
`define BIT_IRQ_OPEN_DRAIN 2
`define BIT_IRQ_GP_MODE 3
`define BIT_IRQ_GP_VALUE 4
`define BIT_EV_REF_LOST 0
`define BIT_EV_PIN4_CHANGE 1
`define BIT_EV_SER_FRAME 2

// ==========================================================
// Reset values and widths.
`define RST_IO_PIN_CONFIG 8'h00
`define RST_IRQ_PIN_CONFIG 8'h00
`define RST_INT_MASK 3'h0
`define NUM_EVENTS 3

// ==========================================================
// Serial frame: one read flag, address bits, data bits.
`define SER_ADDR_BITS 7
`define SER_DATA_BITS 8

`endif

//--- verilog/serial_slave.v
/*
  Serial register-access slave. Frame: read flag (1 = read), address
  MSB first, then eight data bits MSB first.
  Assumes cs_n, sclk, sdi and phase come from pins outside the mclk
  domain, and that the serial clock is far slower than mclk_i.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_slave #(
	parameter ADDR_W = 7,
	parameter DATA_W = 8
) (
	// Clock and reset.
	input wire mclk_i,
	input wire rst_i,
	// Serial pins.
	input wire cs_n_i,
	input wire sclk_i,
	input wire sdi_i,
	input wire phase_i,
	output reg sdo_o,
	output wire sdo_oe_n_o,
	// Register access toward the register file.
	output reg [ADDR_W-1:0] addr_o,
	output reg [DATA_W-1:0] wdata_o,
	output reg wr_o,
	output reg rd_o,
	input wire [DATA_W-1:0] rdata_i,
	output reg frame_done_o
);

	localparam FRAME_W = 1 + ADDR_W + DATA_W;
	localparam [4:0] CMD_LAST = ADDR_W;
	localparam [4:0] CMD_BITS = ADDR_W + 1;
	localparam [4:0] FRAME_LAST = FRAME_W - 1;
	localparam [4:0] FRAME_BITS = FRAME_W;

	// ==========================================================
	// Pin synchronisers.
	reg cs_m_q, cs_s_q; // Chip select, two flops.
	reg sclk_m_q, sclk_s_q, sclk_p_q; // Serial clock and its past value.
	reg sdi_m_q, sdi_s_q; // Serial data in.
	reg ph_m_q, ph_s_q; // Clock phase select.

	// Every pin passes two flops; the first is read by the second only.
	always @(posedge mclk_i) begin
		cs_m_q <= cs_n_i;
		cs_s_q <= cs_m_q;
		sclk_m_q <= sclk_i;
		sclk_s_q <= sclk_m_q;
		sclk_p_q <= sclk_s_q;
		sdi_m_q <= sdi_i;
		sdi_s_q <= sdi_m_q;
		ph_m_q <= phase_i;
		ph_s_q <= ph_m_q;
	end

	// ==========================================================
	// Edge detection.
	reg idle_q; // Serial clock level seen while deselected.
	wire edge_w = sclk_s_q ^ sclk_p_q;
	wire lead_w = edge_w & (sclk_p_q == idle_q);
	wire trail_w = edge_w & ~lead_w;
	// Phase 0 samples on the leading edge, phase 1 on the trailing.
	wire samp_w = ph_s_q ? trail_w : lead_w;
	wire drive_w = ph_s_q ? lead_w : trail_w;

	// The idle level is learnt while deselected, so either clock
	// polarity works without a separate setting.
	always @(posedge mclk_i) begin
		if (rst_i) begin
			idle_q <= 1'b0;
		end else if (cs_s_q) begin
			idle_q <= sclk_s_q;
		end
	end

	// ==========================================================
	// Shift engine.
	reg [4:0] cnt_q; // Bits sampled in this frame.
	reg [FRAME_W-1:0] sh_q; // Incoming bits.
	reg [DATA_W-1:0] tx_q; // Outgoing read data.
	reg is_read_q; // Frame is a read.
	reg load_q; // Read data arrives this cycle.

	// Deselect clears the engine; selection restarts at bit zero.
	always @(posedge mclk_i) begin
		if (rst_i || cs_s_q) begin
			cnt_q <= 5'h00;
			sh_q <= {FRAME_W{1'b0}};
			tx_q <= {DATA_W{1'b0}};
			is_read_q <= 1'b0;
			load_q <= 1'b0;
			addr_o <= {ADDR_W{1'b0}};
			wdata_o <= {DATA_W{1'b0}};
			wr_o <= 1'b0;
			rd_o <= 1'b0;
			frame_done_o <= 1'b0;
			sdo_o <= 1'b0;
		end else begin
			wr_o <= 1'b0;
			rd_o <= 1'b0;
			frame_done_o <= 1'b0;
			load_q <= rd_o;
			// Register file answers one cycle after the read strobe.
			if (load_q) begin
				tx_q <= rdata_i;
			end
			// Master data is taken only on the sampling edge.
			if (samp_w && cnt_q < FRAME_BITS) begin
				sh_q <= {sh_q[FRAME_W-2:0], sdi_s_q};
				cnt_q <= cnt_q + 5'h01;
				if (cnt_q == CMD_LAST) begin
					is_read_q <= sh_q[ADDR_W-1];
					rd_o <= sh_q[ADDR_W-1];
					addr_o <= {sh_q[ADDR_W-2:0], sdi_s_q};
				end
				if (cnt_q == FRAME_LAST) begin
					wr_o <= ~is_read_q;
					wdata_o <= {sh_q[DATA_W-2:0], sdi_s_q};
					frame_done_o <= 1'b1;
				end
			end
			// Read data leaves MSB first on the launching edge.
			if (drive_w && cnt_q >= CMD_BITS) begin
				sdo_o <= tx_q[DATA_W-1];
				tx_q <= {tx_q[DATA_W-2:0], 1'b0};
			end
		end
	end

	// The output is released while the device is deselected.
	assign sdo_oe_n_o = cs_s_q;

endmodule // serial_slave

`default_nettype wire

//--- verification/spi_master_model.sv
/*
  Serial bus master model that drives the register port.
  Assumes the bench changes phase and idle level only between frames.
*/
`timescale 1ns/1ps
`default_nettype none

module spi_master_model (
	// Mode inputs and returned data.
	input wire logic phase_i,
	input wire logic cpol_i,
	input wire logic sdo_i,
	// Lines toward the device.
	output logic cs_n_o,
	output logic sclk_o,
	output logic sdi_o
);
	// ==========================================
	// Lines at rest.
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o = 1'b0;
	end
	// Data wanders while deselected, so a stale bit is never trusted.
	always #37 if (cs_n_o) sdi_o = ~sdi_o;

	// Sends the top n bits of w; a short n aborts the frame midway.
	task automatic xfer(input logic [15:0] w, input int n,
		output logic [7:0] r);
		r = 8'h00;
		sclk_o = cpol_i;
		#200 cs_n_o = 1'b0;
		for (int i = 15; i > 15 - n; i--) begin
			if (!phase_i) sdi_o = w[i];
			#62.5 sclk_o = ~sclk_o;
			if (phase_i) sdi_o = w[i];
			else if (i < 8) r[i] = sdo_i;
			#62.5 sclk_o = ~sclk_o;
			if (phase_i && i < 8) r[i] = sdo_i;
		end
		#62.5 cs_n_o = 1'b1;
		#150;
	endtask
endmodule // spi_master_model

`default_nettype wire

//--- verification/spi_port_checker.sv
/*
  Assertions on the ports of the serial port and status pin block.
  Assumes the single clock mclk_i with synchronous reset rst_i.
*/
`timescale 1ns/1ps
`default_nettype none

module spi_port_checker (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic rst_i,
	// Register port.
	input wire logic [6:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	// Pins and modes.
	input wire logic spi_cs_n_i,
	input wire logic spi_sdo_o,
	input wire logic spi_sdo_oe_n_o,
	input wire logic general_io_pin4_i,
	input wire logic general_io_pin4_o,
	input wire logic general_io_pin4_oe_n_o,
	input wire logic interrupt_request_pin_o,
	input wire logic interrupt_request_pin_oe_n_o,
	input wire logic ref_missing_i,
	input wire logic sonet_rate_select_o,
	input wire logic digital_out1_standard_sel_o,
	input wire logic digital_out2_standard_sel_o,
	input wire logic irq_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	// ==========================================
	// Reference-missing mode written, then three quiet cycles.
	sequence ref_mode_set;
		reg_wr_i && reg_addr_i == 7'h04 && reg_wdata_i[0];
	endsequence
	sequence quiet3;
		!reg_wr_i [*3];
	endsequence

	a_rate_latch: assert property ($fell(rst_i) |=>
		sonet_rate_select_o == $past(general_io_pin4_i, 2)
		&& digital_out1_standard_sel_o == sonet_rate_select_o
		&& digital_out2_standard_sel_o == sonet_rate_select_o)
		else $error("rate defaults not loaded");
	a_reset_state: assert property ($fell(rst_i) |-> !irq_o
		&& general_io_pin4_oe_n_o && interrupt_request_pin_oe_n_o)
		else $error("outputs not at reset state");
	a_sdo_release: assert property (spi_cs_n_i [*5] |->
		spi_sdo_oe_n_o && !spi_sdo_o) else $error("sdo driven idle");
	a_sdo_drive: assert property (!spi_cs_n_i [*5] |->
		!spi_sdo_oe_n_o) else $error("sdo not driven");
	// The register lands on the write edge, the pin flop one edge later.
	a_pin4_cfg: assert property (reg_wr_i && reg_addr_i == 7'h02
		|-> ##2 general_io_pin4_o == $past(reg_wdata_i[1], 2)
		&& general_io_pin4_oe_n_o == !$past(reg_wdata_i[0], 2))
		else $error("rate pin drive wrong");
	a_rate_read: assert property (reg_rd_i && reg_addr_i == 7'h00 |=>
		reg_rdata_o[0] == $past(sonet_rate_select_o))
		else $error("rate bit read wrong");
	a_ref_follow: assert property (ref_mode_set ##1 quiet3 |->
		interrupt_request_pin_o == $past(ref_missing_i)
		&& !interrupt_request_pin_oe_n_o) else $error("pin not live");
	a_mask_off: assert property (reg_wr_i && reg_addr_i == 7'h06
		&& reg_wdata_i[2:0] == 3'h0 |=> !irq_o)
		else $error("irq while all masked");
endmodule // spi_port_checker

`default_nettype wire

//--- verification/spi_port_and_status_pins_bench.sv
/*
  Self-checking bench for the serial port and status pin block.
  Assumes the design under verilog/ and the serial master model.
*/
`include "spi_port_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module spi_port_and_status_pins_bench;
	// ==========================================
	// Stimulus and observed pins.
	logic mclk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic ref_missing_i = 1'b0, cpol = 1'b0, ext_val = 1'b0;
	logic serial_clock_phase_select_i = 1'b0;
	logic [6:0] reg_addr_i = 7'h00;
	logic [7:0] reg_wdata_i = 8'h00, d, v, r;
	logic [7:0] cfgs[6] = '{8'h00, 8'h02, 8'h06, 8'h04, 8'h18, 8'h1C};
	wire [7:0] reg_rdata_o;
	wire spi_cs_n_i, spi_sclk_i, spi_sdi_i, spi_sdo_o, spi_sdo_oe_n_o;
	wire general_io_pin4_o, general_io_pin4_oe_n_o, irq_o;
	wire interrupt_request_pin_o, interrupt_request_pin_oe_n_o;
	wire sonet_rate_select_o, digital_out1_standard_sel_o;
	wire digital_out2_standard_sel_o, freq_1544_avail_o, freq_2048_avail_o;
	int n_fail = 0, check_count = 0;
	// The pad: own drive while enabled, else the outside level.
	wire general_io_pin4_i = general_io_pin4_oe_n_o ? ext_val
		: general_io_pin4_o;

	spi_port_and_status_pins dut (.mclk_i, .rst_i, .reg_addr_i,
		.reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .spi_cs_n_i,
		.spi_sclk_i, .spi_sdi_i, .serial_clock_phase_select_i, .spi_sdo_o,
		.spi_sdo_oe_n_o, .general_io_pin4_i, .general_io_pin4_o,
		.general_io_pin4_oe_n_o, .interrupt_request_pin_o,
		.interrupt_request_pin_oe_n_o, .ref_missing_i, .sonet_rate_select_o,
		.digital_out1_standard_sel_o, .digital_out2_standard_sel_o,
		.freq_1544_avail_o, .freq_2048_avail_o, .irq_o);
	spi_master_model m (.phase_i(serial_clock_phase_select_i),
		.cpol_i(cpol), .sdo_i(spi_sdo_o), .cs_n_o(spi_cs_n_i),
		.sclk_o(spi_sclk_i), .sdi_o(spi_sdi_i));

	always #5 mclk_i = ~mclk_i;

	// ==========================================
	// Compare, bus cycles and expectations.
	task automatic chk(input string n, input logic [7:0] e, g);
		check_count++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] x);
		@(posedge mclk_i);
		reg_wr_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= x;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask
	// Read data stand from the cycle after the strobe until the next read.
	task automatic rd(input logic [6:0] a, output logic [7:0] x);
		@(posedge mclk_i);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
		@(negedge mclk_i);
		x = reg_rdata_o;
	endtask
	task automatic settle;
		repeat (3) @(negedge mclk_i);
	endtask
	// Expected {enable_n, level} of the interrupt pin.
	function automatic logic [1:0] pin_exp(input logic [7:0] c, q);
		logic l;
		l = c[3] ? c[4] : (c[1] ? q[0] : !q[0]);
		return {c[2] & l, l};
	endfunction
	task automatic finish_test;
		$display("checks %0d mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// ==========================================
	// Main sequence.
	initial begin
		void'($urandom(32'h8729));
		for (int k = 0; k < 2; k++) begin
			ext_val <= k[0];
			if (k > 0) repeat (3) @(posedge mclk_i);
			rst_i <= 1'b1;
			repeat (3) @(posedge mclk_i);
			rst_i <= 1'b0;
			settle;
			chk("rate", 8'(k[0]), 8'(sonet_rate_select_o));
			chk("dig", {6'h0, {2{k[0]}}}, {6'h0,
				digital_out2_standard_sel_o, digital_out1_standard_sel_o});
			chk("freq", {6'h0, k[0], !k[0]},
				{6'h0, freq_1544_avail_o, freq_2048_avail_o});
			rd(`OFS_IRQ_PIN_CONFIG, v);
			chk("icfg", `RST_IRQ_PIN_CONFIG, v);
			rd(`OFS_MASTER_CFG_THREE, v);
			chk("cfg3", 8'(k[0]), 8'(v[0]));
		end
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			d = $urandom;
			ext_val <= $urandom;
			wr(`OFS_IO_PIN_CONFIG, d);
			settle;
			chk("p4", {6'h0, !d[0], d[1]}, {6'h0,
				general_io_pin4_oe_n_o, general_io_pin4_o});
			rd(`OFS_IO_PIN_STATE, v);
			chk("p4st", 8'(d[0] ? d[1] : ext_val), 8'(v[0]));
		end
		$display("io test done");
		ref_missing_i <= 1'b1;
		for (int q = 1; q >= 0; q--) begin
			wr(`OFS_INT_MASK, 8'(q));
			settle;
			chk("irq", 8'(q), 8'(irq_o));
			foreach (cfgs[j]) begin
				wr(`OFS_IRQ_PIN_CONFIG, cfgs[j]);
				settle;
				chk("pin", 8'(pin_exp(cfgs[j], q)), {6'h0,
					interrupt_request_pin_oe_n_o, interrupt_request_pin_o});
			end
		end
		wr(`OFS_INT_STATUS, 8'h01);
		wr(`OFS_INT_MASK, 8'h01);
		settle;
		chk("w1c", 8'h00, 8'(irq_o));
		wr(`OFS_IRQ_PIN_CONFIG, 8'h01);
		settle;
		for (int i = 0; i < 20; i++) begin
			@(posedge mclk_i);
			ref_missing_i <= $urandom;
			@(negedge mclk_i);
			if (i > 0) chk("los", 8'(r[0]), 8'(interrupt_request_pin_o));
			r[0] = ref_missing_i;
		end
		$display("interrupt pin test done");
		for (int k = 0; k < 4; k++) begin
			serial_clock_phase_select_i <= k[0];
			cpol <= k[1];
			d = $urandom;
			settle;
			m.xfer({1'b0, `OFS_INT_MASK, d}, 16, r);
			rd(`OFS_INT_MASK, v);
			chk("swr", 8'(d[2:0]), 8'(v[2:0]));
			m.xfer({1'b0, `OFS_INT_MASK, ~d}, 12, r);
			m.xfer({1'b1, `OFS_INT_MASK, 8'h00}, 16, r);
			chk("srd", {5'h00, d[2:0]}, r);
		end
		// Whole frames leave their event behind; a cut frame must not.
		rd(`OFS_INT_STATUS, v);
		chk("frame", 8'h01, 8'(v[`BIT_EV_SER_FRAME]));
		wr(`OFS_INT_STATUS, 8'h04);
		m.xfer({1'b0, `OFS_INT_MASK, 8'h00}, 12, r);
		rd(`OFS_INT_STATUS, v);
		chk("cut", 8'h00, 8'(v[`BIT_EV_SER_FRAME]));
		$display("serial test done");
		finish_test;
	end

	// A hung handshake ends the run here instead.
	initial begin
		#200us;
		n_fail++;
		finish_test;
	end
endmodule // spi_port_and_status_pins_bench

bind spi_port_and_status_pins spi_port_checker chk_u (.mclk_i, .rst_i,
	.reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
	.spi_cs_n_i, .spi_sdo_o, .spi_sdo_oe_n_o, .general_io_pin4_i,
	.general_io_pin4_o, .general_io_pin4_oe_n_o, .interrupt_request_pin_o,
	.interrupt_request_pin_oe_n_o, .ref_missing_i, .sonet_rate_select_o,
	.digital_out1_standard_sel_o, .digital_out2_standard_sel_o, .irq_o);

`default_nettype wire
